// ==== prcg_defs.vh ====
// Purpose: Constants for the peripheral reset and clock gating block
// Assumes: Avalon-MM byte addressing, 32-bit data
// Notes: Included by the top-level design file only; the clock gate does not include it
`ifndef PRCG_DEFS_VH
`define PRCG_DEFS_VH
`define PRCG_ADDR_W 8
`define PRCG_OFS_RST 8'h10
`define PRCG_OFS_SYSEN 8'h14
`define PRCG_OFS_HIEN 8'h18
`define PRCG_RST_RESET 32'h00000000
`define PRCG_SYSEN_RESET 32'h00000014
`define PRCG_HIEN_RESET 32'h00000000
`define PRCG_RST_MASK 32'h787ec9ff
`define PRCG_SYSEN_MASK 32'h00000157
`define PRCG_HIEN_MASK 32'h00075bfd
// Reset request field positions
`define PRCG_RB_CEC_UNIT 30
`define PRCG_RB_DAC_IF 29
`define PRCG_RB_POWER_IF 28
`define PRCG_RB_BACKUP_IF 27
`define PRCG_RB_I2C_TWO 22
`define PRCG_RB_I2C_ONE 21
`define PRCG_RB_UART_FIVE 20
`define PRCG_RB_UART_FOUR 19
`define PRCG_RB_USART_THREE 18
`define PRCG_RB_USART_TWO 17
`define PRCG_RB_SPI_THREE 15
`define PRCG_RB_SPI_TWO 14
`define PRCG_RB_WATCHDOG 11
`define PRCG_RB_TIMER14 8
`define PRCG_RB_TIMER13 7
`define PRCG_RB_TIMER12 6
`define PRCG_RB_TIMER7 5
`define PRCG_RB_TIMER6 4
`define PRCG_RB_TIMER5 3
`define PRCG_RB_TIMER4 2
`define PRCG_RB_TIMER3 1
`define PRCG_RB_TIMER2 0
// System bus enable field positions
`define PRCG_SB_DMA_ONE 0
`define PRCG_SB_DMA_TWO 1
`define PRCG_SB_SRAM_SLEEP 2
`define PRCG_SB_FLASH_SLEEP 4
`define PRCG_SB_CHECKSUM 6
`define PRCG_SB_STATIC_MEM 8
// High bus enable field positions
`define PRCG_HB_ALT_FUNC_IO 0
`define PRCG_HB_PORT_A 2
`define PRCG_HB_PORT_B 3
`define PRCG_HB_PORT_C 4
`define PRCG_HB_PORT_D 5
`define PRCG_HB_PORT_E 6
`define PRCG_HB_PORT_F 7
`define PRCG_HB_PORT_G 8
`define PRCG_HB_ADC_ONE 9
`define PRCG_HB_TIMER1 11
`define PRCG_HB_SPI_ONE 12
`define PRCG_HB_USART_ONE 14
`define PRCG_HB_TIMER15 16
`define PRCG_HB_TIMER16 17
`define PRCG_HB_TIMER17 18
`endif

// ==== prcg_clk_gate.v ====
// Purpose: Glitch-free clock gate for one peripheral clock
// Assumes: Enable changes synchronous to rising edge of clk
// Notes: Enable is captured on the falling edge, so it only moves while clk is low
`timescale 1ns/10ps
module prcg_clk_gate (
  // Clock in
  input wire clk,
  // Enable
  input wire en,
  // Gated clock
  output wire gclk
);
  reg en_lat_r;

  // ************************************************************
  // Falling edge gate
  // ************************************************************
  // glitch free gating
  always @(negedge clk) begin
    en_lat_r <= en;
  end

  assign gclk = clk & en_lat_r;
endmodule // prcg_clk_gate

// ==== prcg_top.v ====
// Purpose: Peripheral reset requests and clock enables with gated clocks
// Assumes: Avalon-MM slave, byte addresses, clk 125 MHz
// Notes: Reserved bits read zero; unmapped reads return zero
`include "prcg_defs.vh"
`timescale 1ns/10ps
module prcg_top (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Avalon-MM slave
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // System state
  input wire sleep_mode,
  input wire high_bus_busy,
  // Peripheral resets, one bit per register bit
  output reg [31:0] low_bus_reset_req,
  // Clock enables
  output reg [31:0] sys_bus_clk_en,
  output reg [31:0] high_bus_clk_en,
  // Gated clocks
  output wire [31:0] sys_bus_gclk,
  output wire [31:0] high_bus_gclk
);

  // ************************************************************
  // Layout constants
  // ************************************************************
  localparam [31:0] RST_MASK = `PRCG_RST_MASK;
  localparam [31:0] SYS_MASK = `PRCG_SYSEN_MASK;
  localparam [31:0] HI_MASK = `PRCG_HIEN_MASK;
  localparam integer NUM_GATES = 32;

  // ************************************************************
  // Internal state
  // ************************************************************
  reg [31:0] rst_r;
  reg [31:0] sysen_r;
  reg [31:0] hien_r;
  reg [31:0] rst_out_nxt;
  reg [31:0] sys_gate_nxt;
  reg [31:0] hi_gate_nxt;
  wire [31:0] be_mask;
  wire sel_rst;
  wire sel_sys;
  wire sel_hi;
  wire bus_req;
  wire hi_stall;
  wire wr_go;
  wire wr_rst;
  wire wr_sys;
  wire wr_hi;

  // ************************************************************
  // Helpers
  // ************************************************************
  function [31:0] merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [31:0] be;
    input [31:0] mask;
    begin
      merge = ((old_v & ~be) | (new_v & be)) & mask;
    end
  endfunction

  function hit;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      hit = (addr == ofs);
    end
  endfunction

  // ************************************************************
  // Decode
  // ************************************************************
  assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign sel_rst = hit(avs_address, `PRCG_OFS_RST);
  assign sel_sys = hit(avs_address, `PRCG_OFS_SYSEN);
  assign sel_hi = hit(avs_address, `PRCG_OFS_HIEN);
  assign bus_req = avs_read | avs_write;
  assign hi_stall = sel_hi & bus_req & high_bus_busy;
  assign wr_go = avs_write & ~hi_stall;

  // ************************************************************
  // Write strobes
  // ************************************************************
  // writes land in the request cycle
  assign wr_rst = wr_go & sel_rst;
  assign wr_sys = wr_go & sel_sys;
  assign wr_hi = wr_go & sel_hi;

  // ************************************************************
  // Registers
  // ************************************************************
  // reset register store
  always @(posedge clk) begin
    if (!rst_n) begin
      rst_r <= `PRCG_RST_RESET;
    end else if (wr_rst) begin
      rst_r <= merge(rst_r, avs_writedata, be_mask, RST_MASK);
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      sysen_r <= `PRCG_SYSEN_RESET;
    end else if (wr_sys) begin
      sysen_r <= merge(sysen_r, avs_writedata, be_mask, SYS_MASK);
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      hien_r <= `PRCG_HIEN_RESET;
    end else if (wr_hi) begin
      hien_r <= merge(hien_r, avs_writedata, be_mask, HI_MASK);
    end
  end

  // ************************************************************
  // Bus answer
  // ************************************************************
  // reserved bits read zero
  // Read data stand in the request cycle; only a high bus access while high_bus_busy gets wait states
  always @* begin
    avs_readdata = 32'h00000000;
    if (sel_rst) begin
      avs_readdata = rst_r & RST_MASK;
    end else if (sel_sys) begin
      avs_readdata = sysen_r & SYS_MASK;
    end else if (sel_hi) begin
      avs_readdata = hien_r & HI_MASK;
    end
  end

  always @* begin
    avs_waitrequest = hi_stall;
  end

  // ************************************************************
  // Reset request map
  // ************************************************************
  // interface resets
  always @* begin
    rst_out_nxt = 32'h00000000;
    rst_out_nxt[`PRCG_RB_CEC_UNIT] = rst_r[`PRCG_RB_CEC_UNIT];
    rst_out_nxt[`PRCG_RB_DAC_IF] = rst_r[`PRCG_RB_DAC_IF];
    rst_out_nxt[`PRCG_RB_POWER_IF] = rst_r[`PRCG_RB_POWER_IF];
    rst_out_nxt[`PRCG_RB_BACKUP_IF] = rst_r[`PRCG_RB_BACKUP_IF];
    // Serial units
    rst_out_nxt[`PRCG_RB_I2C_TWO] = rst_r[`PRCG_RB_I2C_TWO];
    rst_out_nxt[`PRCG_RB_I2C_ONE] = rst_r[`PRCG_RB_I2C_ONE];
    rst_out_nxt[`PRCG_RB_UART_FIVE] = rst_r[`PRCG_RB_UART_FIVE];
    rst_out_nxt[`PRCG_RB_UART_FOUR] = rst_r[`PRCG_RB_UART_FOUR];
    rst_out_nxt[`PRCG_RB_USART_THREE] = rst_r[`PRCG_RB_USART_THREE];
    rst_out_nxt[`PRCG_RB_USART_TWO] = rst_r[`PRCG_RB_USART_TWO];
    rst_out_nxt[`PRCG_RB_SPI_THREE] = rst_r[`PRCG_RB_SPI_THREE];
    rst_out_nxt[`PRCG_RB_SPI_TWO] = rst_r[`PRCG_RB_SPI_TWO];
    // Watchdog
    rst_out_nxt[`PRCG_RB_WATCHDOG] = rst_r[`PRCG_RB_WATCHDOG];
    // Timers
    rst_out_nxt[`PRCG_RB_TIMER14] = rst_r[`PRCG_RB_TIMER14];
    rst_out_nxt[`PRCG_RB_TIMER13] = rst_r[`PRCG_RB_TIMER13];
    rst_out_nxt[`PRCG_RB_TIMER12] = rst_r[`PRCG_RB_TIMER12];
    rst_out_nxt[`PRCG_RB_TIMER7] = rst_r[`PRCG_RB_TIMER7];
    rst_out_nxt[`PRCG_RB_TIMER6] = rst_r[`PRCG_RB_TIMER6];
    rst_out_nxt[`PRCG_RB_TIMER5] = rst_r[`PRCG_RB_TIMER5];
    rst_out_nxt[`PRCG_RB_TIMER4] = rst_r[`PRCG_RB_TIMER4];
    rst_out_nxt[`PRCG_RB_TIMER3] = rst_r[`PRCG_RB_TIMER3];
    rst_out_nxt[`PRCG_RB_TIMER2] = rst_r[`PRCG_RB_TIMER2];
  end

  // ************************************************************
  // System bus gates
  // ************************************************************
  // system bus gates
  always @* begin
    sys_gate_nxt = 32'h00000000;
    sys_gate_nxt[`PRCG_SB_DMA_ONE] = sysen_r[`PRCG_SB_DMA_ONE];
    sys_gate_nxt[`PRCG_SB_DMA_TWO] = sysen_r[`PRCG_SB_DMA_TWO];
    sys_gate_nxt[`PRCG_SB_CHECKSUM] = sysen_r[`PRCG_SB_CHECKSUM];
    sys_gate_nxt[`PRCG_SB_STATIC_MEM] = sysen_r[`PRCG_SB_STATIC_MEM];
    // Awake, these two clocks always run
    sys_gate_nxt[`PRCG_SB_SRAM_SLEEP] = sysen_r[`PRCG_SB_SRAM_SLEEP] | ~sleep_mode;
    sys_gate_nxt[`PRCG_SB_FLASH_SLEEP] = sysen_r[`PRCG_SB_FLASH_SLEEP] | ~sleep_mode;
  end

  // ************************************************************
  // High bus gates
  // ************************************************************
  // high bus gates
  always @* begin
    hi_gate_nxt = 32'h00000000;
    hi_gate_nxt[`PRCG_HB_TIMER17] = hien_r[`PRCG_HB_TIMER17];
    hi_gate_nxt[`PRCG_HB_TIMER16] = hien_r[`PRCG_HB_TIMER16];
    hi_gate_nxt[`PRCG_HB_TIMER15] = hien_r[`PRCG_HB_TIMER15];
    hi_gate_nxt[`PRCG_HB_USART_ONE] = hien_r[`PRCG_HB_USART_ONE];
    hi_gate_nxt[`PRCG_HB_SPI_ONE] = hien_r[`PRCG_HB_SPI_ONE];
    hi_gate_nxt[`PRCG_HB_TIMER1] = hien_r[`PRCG_HB_TIMER1];
    hi_gate_nxt[`PRCG_HB_ADC_ONE] = hien_r[`PRCG_HB_ADC_ONE];
    // Ports and alternate function IO
    hi_gate_nxt[`PRCG_HB_PORT_G] = hien_r[`PRCG_HB_PORT_G];
    hi_gate_nxt[`PRCG_HB_PORT_F] = hien_r[`PRCG_HB_PORT_F];
    hi_gate_nxt[`PRCG_HB_PORT_E] = hien_r[`PRCG_HB_PORT_E];
    hi_gate_nxt[`PRCG_HB_PORT_D] = hien_r[`PRCG_HB_PORT_D];
    hi_gate_nxt[`PRCG_HB_PORT_C] = hien_r[`PRCG_HB_PORT_C];
    hi_gate_nxt[`PRCG_HB_PORT_B] = hien_r[`PRCG_HB_PORT_B];
    hi_gate_nxt[`PRCG_HB_PORT_A] = hien_r[`PRCG_HB_PORT_A];
    hi_gate_nxt[`PRCG_HB_ALT_FUNC_IO] = hien_r[`PRCG_HB_ALT_FUNC_IO];
  end

  // ************************************************************
  // Output flops
  // ************************************************************
  always @(posedge clk) begin
    if (!rst_n) begin
      low_bus_reset_req <= 32'h00000000;
    end else begin
      low_bus_reset_req <= rst_out_nxt;
    end
  end

  // Reset value matches the awake view of the enable register
  always @(posedge clk) begin
    if (!rst_n) begin
      sys_bus_clk_en <= `PRCG_SYSEN_RESET;
    end else begin
      sys_bus_clk_en <= sys_gate_nxt;
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      high_bus_clk_en <= 32'h00000000;
    end else begin
      high_bus_clk_en <= hi_gate_nxt;
    end
  end

  // ************************************************************
  // Clock gates
  // ************************************************************
  // one gate per enable
  genvar gi;
  generate
    for (gi = 0; gi < NUM_GATES; gi = gi + 1) begin : g_gate
      prcg_clk_gate u_sys (
        .clk(clk),
        .en(sys_bus_clk_en[gi]),
        .gclk(sys_bus_gclk[gi])
      );
      prcg_clk_gate u_hi (
        .clk(clk),
        .en(high_bus_clk_en[gi]),
        .gclk(high_bus_gclk[gi])
      );
    end
  endgenerate

  // readback zeroing lies in each peripheral, driven by these enables
endmodule // prcg_top

// ==== prcg_chk_assertions.sv ====
// Purpose: port checks for prcg_top. Assumes: sync active-low reset
// Notes: bound to every prcg_top at the foot
`timescale 1ns/10ps
module prcg_chk (
  // Clock, reset and bus
  input wire clk,
  input wire rst_n,
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  input wire avs_waitrequest,
  input wire high_bus_busy,
  input wire sleep_mode,
  // Outputs
  input wire [31:0] low_bus_reset_req,
  input wire [31:0] sys_bus_clk_en,
  input wire [31:0] high_bus_clk_en
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire wr = avs_write & !avs_waitrequest & (avs_byteenable == 4'hf);
  a_rst_resv: assert property ((low_bus_reset_req & ~32'h787ec9ff) == 0) else $error("rst rsv");
  a_sys_resv: assert property (sys_bus_clk_en[31:9] == 0) else $error("sys rsv");
  a_low_nowait: assert property ((avs_read | avs_write) && avs_address inside {8'h10, 8'h14} |-> !avs_waitrequest)
    else $error("wait");
  a_hi_stall: assert property ((avs_read | avs_write) && avs_address == 8'h18 && high_bus_busy |-> avs_waitrequest)
    else $error("no stall");
  a_sys_reset: assert property ($rose(rst_n) |-> sys_bus_clk_en == 32'h14) else $error("sys init");
  a_rst_write: assert property (wr && avs_address == 8'h10 |-> ##2
    low_bus_reset_req == ($past(avs_writedata, 2) & 32'h787ec9ff)) else $error("rst wr");
  a_sys_write: assert property (wr && avs_address == 8'h14 |-> ##2
    sys_bus_clk_en == (($past(avs_writedata, 2) & 32'h157) | ($past(sleep_mode) ? 32'h0 : 32'h14)))
    else $error("sys wr");
  a_hi_write: assert property (wr && avs_address == 8'h18 |-> ##2
    high_bus_clk_en == ($past(avs_writedata, 2) & 32'h75bfd)) else $error("hi wr");
  cover property (wr && avs_address == 8'h18);
  cover property (avs_waitrequest);
  cover property (avs_read && !avs_waitrequest);
endmodule // prcg_chk
bind prcg_top prcg_chk u_prcg_chk (.*);

// ==== prcg_top_tb.sv ====
// Purpose: bench for prcg_top. Assumes: waitrequest handshake
// Notes: directed tasks only
`timescale 1ns/10ps
module prcg_top_tb;
  logic clk = 0, rst_n = 0, avs_read = 0, avs_write = 0, sleep_mode = 0, high_bus_busy = 0, avs_waitrequest;
  logic [7:0] avs_address = 0;
  logic [3:0] avs_byteenable = 0;
  logic [31:0] avs_writedata = 0, avs_readdata, low_bus_reset_req, sys_bus_clk_en, high_bus_clk_en, q, g;
  int err_total = 0, tests_run = 0, n;
  prcg_top u_prcg_top (.*, .sys_bus_gclk(g), .high_bus_gclk());
  initial forever #4 clk = ~clk;
  task close_out;
    if (err_total == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input string s, input logic [31:0] e, v);
    tests_run++;
    err_total += (v !== e);
    if (v !== e) $display("BAD %s exp %h seen %h", s, e, v);
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    avs_byteenable <= b;
    @(posedge clk);
    for (n = 1; avs_waitrequest !== 1'b0 && n < 40; n++) @(posedge clk);
    q = avs_readdata;
    avs_write <= 0;
    avs_read <= 0;
    err_total += (n >= 40);
    if (n >= 40) close_out;
    @(posedge clk);
  endtask
  task automatic t_regs;
    logic [31:0] r[3] = '{0, 32'h14, 0};
    logic [31:0] m[3] = '{32'h787ec9ff, 32'h157, 32'h75bfd};
    for (int i = 0; i < 3; i++) begin
      bus(0, 8'h10 + 8'(4 * i), 0, 4'hf);
      chk("init", r[i], q);
      bus(1, 8'h10 + 8'(4 * i), '1, 4'hf);
      bus(0, 8'h10 + 8'(4 * i), 0, 4'hf);
      chk("mask", m[i], q);
    end
    bus(1, 8'h10, 0, 4'h2);
    @(posedge clk);
    chk("byte", 32'h787e00ff, low_bus_reset_req);
  endtask
  task t_stall;
    high_bus_busy <= 1;
    fork
      bus(1, 8'h18, 0, 4'hf);
      begin
        repeat (3) @(posedge clk);
        chk("stall", 1, avs_waitrequest);
        high_bus_busy <= 0;
      end
    join
    @(posedge clk);
    chk("hi", 0, high_bus_clk_en);
  endtask
  task t_sleep;
    bus(1, 8'h14, 0, 4'hf);
    sleep_mode <= 1;
    repeat (2) @(posedge clk);
    #1;
    chk("sleep", 0, sys_bus_clk_en);
    chk("gclk off", 0, g & 32'h14);
    @(posedge clk);
    sleep_mode <= 0;
    repeat (2) @(posedge clk);
    #1;
    chk("wake", 32'h14, sys_bus_clk_en);
    chk("gclk on", 32'h14, g & 32'h14);
    @(posedge clk);
  endtask
  task t_reset;
    rst_n <= 0;
    repeat (2) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    chk("rst out", 0, low_bus_reset_req);
    bus(0, 8'h14, 0, 4'hf);
    chk("rst sys", 32'h14, q);
    bus(0, 8'h10, 0, 4'hf);
    chk("rst low", 0, q);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    t_regs;
    t_stall;
    t_sleep;
    t_reset;
    close_out;
  end
endmodule // prcg_top_tb
